/* File: swac_top.sv */
// serial port wait, acknowledge and interrupt-condition control with avalon-mm registers
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module swac_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire swac_pkg::swac_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire swac_pkg::swac_word_t avs_writedata,
  input wire swac_pkg::swac_be_t avs_byteenable,
  output swac_pkg::swac_word_t avs_readdata,
  output logic avs_waitrequest,
  // shift clock pin, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // serial data pin, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import swac_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    swac_bus_e bus;
    logic waitreq;
    logic [31:0] rdata;
    logic [1:0] wcond;
    logic released;
    logic ack;
    logic forced;
    logic [1:0] imode;
    logic i2c;
    logic tx;
    logic master;
    logic irq;
    logic busy;
    logic start_seen;
    logic addr_arm;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic gen_high;
    logic [9:0] div;
    logic scl_oe;
    logic sda_oe;
  } swac_state_s;

  swac_state_s st;
  swac_state_s nx;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_push;
  logic fifo_pop;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic frozen;
  logic halt;
  logic irq_set;
  logic [3:0] cnt_max;
  logic [3:0] cnt_inc;
  logic [5:0] idx;
  logic [3:0] wait_rd;
  logic [31:0] rd_mux;
  logic wr_now;

  // ---------------------------------------------------------------
  // receive fifo
  // ---------------------------------------------------------------
  swac_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_push),
    .in_data(nx.shreg), // the byte with the bit shifted in this cycle
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_pop)
  );

  // ---------------------------------------------------------------
  // decode and read mux
  // ---------------------------------------------------------------
  assign idx = avs_address[7:2];
  assign wr_now = (st.bus == BUS_DONE) && avs_write && avs_byteenable[0];
  assign fifo_pop = (st.bus == BUS_DONE) && avs_read && (idx == IDX_RX_DATA);
  // ack bit only has meaning in i2c mode
  assign wait_rd = {st.ack && st.i2c, st.released, st.wcond};

  // unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_IRQ_MODE: rd_mux[1:0] = st.imode;
      IDX_START_STOP: rd_mux[1:0] = {st.start_seen, st.busy};
      IDX_WAIT_ACK: rd_mux[3:0] = wait_rd;
      IDX_JUDGE: rd_mux[0] = !st.released;
      IDX_CONFIG: rd_mux[2:0] = {st.master, st.tx, st.i2c};
      IDX_IRQ_FLAG: rd_mux[0] = st.irq;
      IDX_RX_DATA: rd_mux[8:0] = {fifo_out_valid, fifo_out_data};
      IDX_TX_DATA: rd_mux[7:0] = st.shreg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // pin edge and condition detection on synchronised samples
  // ---------------------------------------------------------------
  assign scl_rise = st.scl_s && !st.scl_d;
  assign scl_fall = !st.scl_s && st.scl_d;
  assign start_ev = st.i2c && st.scl_s && st.scl_d && st.sda_d && !st.sda_s;
  assign stop_ev = st.i2c && st.scl_s && st.scl_d && !st.sda_d && st.sda_s;
  // a full fifo stalls the link just like a wait, so no byte is lost
  assign frozen = !st.released || !fifo_in_ready;
  assign cnt_max = st.i2c ? CNT_MAX_I2C : CNT_MAX_SERIAL;
  assign cnt_inc = (st.cnt == cnt_max) ? CNT_ZERO : (st.cnt + 4'h1);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nx = st;
    halt = 1'b0;
    irq_set = 1'b0;
    fifo_push = 1'b0;
    // two-stage synchronisers, then one stage of history
    nx.scl_m = scl_i;
    nx.scl_s = st.scl_m;
    nx.scl_d = st.scl_s;
    nx.sda_m = sda_i;
    nx.sda_s = st.sda_m;
    nx.sda_d = st.sda_s;

    // bus handshake: request seen, data fetched, answer with waitrequest low
    case (st.bus)
      BUS_IDLE: begin
        nx.waitreq = 1'b1;
        if (avs_read || avs_write) begin
          nx.bus = BUS_FETCH;
        end
      end
      BUS_FETCH: begin
        nx.rdata = avs_read ? rd_mux : 32'h0000_0000;
        nx.waitreq = 1'b0;
        nx.bus = BUS_DONE;
      end
      BUS_DONE: begin
        nx.waitreq = 1'b1;
        nx.bus = BUS_IDLE;
      end
      default: begin
        nx.waitreq = 1'b1;
        nx.bus = BUS_IDLE;
      end
    endcase

    // register writes take effect at the answering edge
    if (wr_now) begin
      case (idx)
        IDX_IRQ_MODE: nx.imode = avs_writedata[1:0];
        IDX_WAIT_ACK: begin
          nx.wcond = avs_writedata[WAIT_COND_LSB +: 2];
          if (st.i2c && !st.tx) begin
            nx.ack = avs_writedata[ACK_LEVEL_POS];
          end
          if (avs_writedata[WAIT_RELEASE_POS] && !st.released) begin
            nx.released = 1'b1;
            if (st.tx && st.cnt == CNT_ZERO) begin
              nx.sda_oe = !st.shreg[7];
              nx.shreg = {st.shreg[6:0], 1'b0};
            end
          end else if (!avs_writedata[WAIT_RELEASE_POS] && st.released) begin
            nx.forced = 1'b1;
          end
        end
        IDX_CONFIG: begin
          nx.i2c = avs_writedata[CFG_I2C_POS];
          nx.tx = avs_writedata[CFG_TX_POS];
          nx.master = avs_writedata[CFG_MASTER_POS];
          if (st.i2c && !avs_writedata[CFG_I2C_POS]) begin
            nx.cnt = CNT_ZERO;
          end
        end
        IDX_IRQ_FLAG: begin
          if (avs_writedata[0]) begin
            nx.irq = 1'b0;
          end
        end
        IDX_TX_DATA: begin
          if (!st.released) begin
            nx.shreg = avs_writedata[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // rising edge: count, sample, interrupt points
    if (scl_rise && !frozen) begin
      nx.cnt = cnt_inc;
      if (!st.tx) begin
        nx.shreg = {st.shreg[6:0], st.sda_s};
        if (cnt_inc == CNT_EIGHT) begin
          fifo_push = 1'b1;
        end
      end else if (st.i2c && cnt_inc == CNT_NINE) begin
        nx.ack = st.sda_s;
      end
      case (st.imode)
        IRQ_AT7: irq_set = (cnt_inc == CNT_SEVEN);
        IRQ_AT8: irq_set = (cnt_inc == CNT_EIGHT);
        IRQ_START7: irq_set = st.i2c && st.start_seen && (cnt_inc == CNT_SEVEN);
        default: irq_set = 1'b0;
      endcase
      if (st.start_seen && cnt_inc == CNT_SEVEN) begin
        nx.start_seen = 1'b0;
      end
      if (!st.i2c && st.wcond == WAIT_DATA && cnt_inc == CNT_EIGHT) begin
        halt = 1'b1;
      end
    end

    // falling edge: drive data or acknowledge, wait points
    if (scl_fall && !frozen) begin
      if (st.tx && st.cnt < CNT_EIGHT) begin
        nx.sda_oe = !st.shreg[7];
        nx.shreg = {st.shreg[6:0], 1'b0};
      end else if (!st.tx && st.i2c && st.cnt == CNT_EIGHT) begin
        nx.sda_oe = !st.ack;
      end else begin
        nx.sda_oe = 1'b0;
      end
      if (st.i2c) begin
        case (st.wcond)
          WAIT_DATA: halt = (st.cnt == CNT_EIGHT);
          WAIT_ACK: halt = (st.cnt == CNT_NINE);
          WAIT_ADDR: halt = st.addr_arm && (st.cnt == CNT_EIGHT);
          default: halt = 1'b0;
        endcase
        if (st.addr_arm && st.cnt == CNT_EIGHT) begin
          nx.addr_arm = 1'b0;
        end
      end
      if (st.forced) begin
        halt = 1'b1;
      end
    end

    // start and stop conditions
    if (start_ev) begin
      nx.cnt = CNT_ZERO;
      nx.busy = 1'b1;
      nx.start_seen = 1'b1;
      nx.addr_arm = 1'b1;
    end
    if (stop_ev) begin
      nx.busy = 1'b0;
      irq_set = irq_set || (st.imode == IRQ_STOP);
    end

    // entering wait status; a release written this cycle still wins
    if (halt && !(wr_now && idx == IDX_WAIT_ACK && avs_writedata[WAIT_RELEASE_POS])) begin
      nx.released = 1'b0;
      nx.forced = 1'b0;
    end
    // the event beats a software clear in the same cycle
    if (irq_set) begin
      nx.irq = 1'b1;
    end

    // master clock generator pauses while a slave stretches the line
    if (st.master && st.released && fifo_in_ready) begin
      if (st.gen_high && !st.scl_s && !st.scl_d) begin
        nx.div = st.div;
      end else if (st.div == SCL_HALF_CYCLES - 10'h001) begin
        nx.div = 10'h000;
        nx.gen_high = !st.gen_high;
      end else begin
        nx.div = st.div + 10'h001;
      end
    end else begin
      nx.div = 10'h000;
      nx.gen_high = 1'b0;
    end
    nx.scl_oe = !nx.released || !fifo_in_ready || (nx.master && !nx.gen_high);
    if (!nx.i2c && !nx.tx) begin
      nx.sda_oe = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register, reset by sys_rst; waitrequest and the pin samples load high
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.bus <= BUS_IDLE;
      st.waitreq <= 1'b1;
      {st.ack, st.released, st.wcond} <= WAIT_ACK_RESET;
      st.imode <= IRQ_MODE_RESET;
      st.scl_m <= 1'b1;
      st.scl_s <= 1'b1;
      st.scl_d <= 1'b1;
      st.sda_m <= 1'b1;
      st.sda_s <= 1'b1;
      st.sda_d <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // outputs; open-drain pins only ever pull low
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign scl_o = 1'b0;
  assign scl_oe = st.scl_oe;
  assign sda_o = 1'b0;
  assign sda_oe = st.sda_oe;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_reset_clear;
    @(posedge sys_clk) $past(sys_rst) |-> (wait_rd == 4'h0 && st.cnt == CNT_ZERO);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("wait register not cleared");

  property p_release;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_now && idx == IDX_WAIT_ACK && avs_writedata[WAIT_RELEASE_POS] && !st.released)
      |=> st.released ##1 !st.scl_oe || st.master || !fifo_in_ready;
  endproperty
  a_release: assert property (p_release) else $error("release did not start transfer");

  property p_forced;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_now && idx == IDX_WAIT_ACK && !avs_writedata[WAIT_RELEASE_POS] && st.released
       && !halt) |=> st.forced && st.released;
  endproperty
  a_forced: assert property (p_forced) else $error("forced wait not armed");

  property p_ack_wait;
    @(posedge sys_clk) disable iff (sys_rst)
      (st.i2c && st.wcond == WAIT_ACK && scl_fall && !frozen && st.cnt == CNT_NINE && !wr_now)
      |=> !st.released ##1 st.scl_oe;
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("no halt at count nine");

  property p_serial_data_wait;
    @(posedge sys_clk) disable iff (sys_rst)
      (!st.i2c && st.wcond == WAIT_DATA && scl_rise && !frozen && cnt_inc == CNT_EIGHT && !wr_now)
      |=> !st.released;
  endproperty
  a_serial_data_wait: assert property (p_serial_data_wait) else $error("serial no halt");

  property p_freeze;
    @(posedge sys_clk) disable iff (sys_rst)
      (frozen && !start_ev && !wr_now) |=> $stable(st.cnt);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while waiting");

  property p_wrap;
    @(posedge sys_clk) disable iff (sys_rst)
      (scl_rise && !frozen && !start_ev && !wr_now && st.cnt == cnt_max) |=> st.cnt == CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_irq_at8;
    @(posedge sys_clk) disable iff (sys_rst)
      (st.imode == IRQ_AT8 && scl_rise && !frozen && cnt_inc == CNT_EIGHT) |=> st.irq [*2];
  endproperty
  a_irq_at8: assert property (p_irq_at8) else $error("irq lost at count eight");

  property p_serial_ack_zero;
    @(posedge sys_clk) disable iff (sys_rst) !st.i2c |-> wait_rd[ACK_LEVEL_POS] == 1'b0;
  endproperty
  a_serial_ack_zero: assert property (p_serial_ack_zero) else $error("ack set in serial");

  property p_judge;
    @(posedge sys_clk) disable iff (sys_rst)
      (st.bus == BUS_FETCH && avs_read && idx == IDX_JUDGE)
      |=> avs_readdata[0] == !$past(st.released);
  endproperty
  a_judge: assert property (p_judge) else $error("judge flag high while released");

endmodule : swac_top

/* File: swac_pkg.sv */
// shared constants and types for the serial wait, acknowledge and interrupt-condition block
package swac_pkg;

  // ---------------------------------------------------------------
  // bus types
  // ---------------------------------------------------------------
  typedef logic [7:0] swac_addr_t;
  typedef logic [31:0] swac_word_t;
  typedef logic [3:0] swac_be_t;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_IRQ_MODE = 6'h0C;
  localparam logic [5:0] IDX_START_STOP = 6'h0D;
  localparam logic [5:0] IDX_WAIT_ACK = 6'h0E;
  localparam logic [5:0] IDX_JUDGE = 6'h0F;
  localparam logic [5:0] IDX_CONFIG = 6'h10;
  localparam logic [5:0] IDX_IRQ_FLAG = 6'h11;
  localparam logic [5:0] IDX_RX_DATA = 6'h12;
  localparam logic [5:0] IDX_TX_DATA = 6'h13;

  // ---------------------------------------------------------------
  // field positions of the wait control register
  // ---------------------------------------------------------------
  localparam int WAIT_COND_LSB = 0;
  localparam int WAIT_RELEASE_POS = 2;
  localparam int ACK_LEVEL_POS = 3;
  // configuration register fields
  localparam int CFG_I2C_POS = 0;
  localparam int CFG_TX_POS = 1;
  localparam int CFG_MASTER_POS = 2;
  // rx data valid flag position in the rx data word
  localparam int RX_VALID_POS = 8;

  // ---------------------------------------------------------------
  // wait conditions and interrupt modes
  // ---------------------------------------------------------------
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_DATA = 2'h1;
  localparam logic [1:0] WAIT_ACK = 2'h2;
  localparam logic [1:0] WAIT_ADDR = 2'h3;
  localparam logic [1:0] IRQ_AT7 = 2'h0;
  localparam logic [1:0] IRQ_AT8 = 2'h1;
  localparam logic [1:0] IRQ_START7 = 2'h2;
  localparam logic [1:0] IRQ_STOP = 2'h3;

  // ---------------------------------------------------------------
  // clock counter figures
  // ---------------------------------------------------------------
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_SEVEN = 4'h7;
  localparam logic [3:0] CNT_EIGHT = 4'h8;
  localparam logic [3:0] CNT_NINE = 4'h9;
  localparam logic [3:0] CNT_MAX_I2C = 4'h9;
  localparam logic [3:0] CNT_MAX_SERIAL = 4'h8;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] WAIT_ACK_RESET = 4'h0;
  localparam logic [1:0] IRQ_MODE_RESET = 2'h0;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC_INT = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] SCL_HALF_CYCLES = SCL_HALF_CYC_INT[9:0];

  // ---------------------------------------------------------------
  // fifo shape
  // ---------------------------------------------------------------
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_DONE} swac_bus_e;

endpackage : swac_pkg

/* File: swac_fifo.sv */
// receive fifo with registered read data and honest full and empty
`timescale 1ns/1ps
module swac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic [WIDTH-1:0] rd_data;
  } swac_fifo_s;

  swac_fifo_s st_reg;
  swac_fifo_s st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  // ---------------------------------------------------------------
  // flow control
  // ---------------------------------------------------------------
  assign in_ready = (st_reg.count != DEPTH[PW:0]);
  assign out_valid = (st_reg.count != '0);
  assign out_data = st_reg.rd_data;
  assign do_push = in_valid && in_ready;
  assign do_pop = out_ready && out_valid;

  // pointer and count update; read data lags a pointer move by one cycle
  always_comb begin
    st_next = st_reg;
    st_next.rd_data = mem[st_reg.rd_ptr];
    if (do_push) begin
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (do_pop && !do_push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // storage, no reset needed since count guards it
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end

endmodule : swac_fifo

/* File: swac_link_model.sv */
// link-side model: bus master that clocks bytes into the shift port
`timescale 1ns/1ps
module swac_link_model (
  // observed clock wire
  input wire logic scl_w,
  // open-drain drives, 1 = released
  output logic scl_drv,
  output logic sda_drv
);
  // ---------------------------------------------------------------
  // idle: both lines released, clock stands still high
  // ---------------------------------------------------------------
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // ---------------------------------------------------------------
  // one clock: low half with data set up, then high half
  // ---------------------------------------------------------------
  task automatic pulse(input logic bit_val);
    scl_drv <= 1'b0;
    #16 sda_drv <= bit_val; // data moves only while the clock is low
    #16 scl_drv <= 1'b1;
    #8;
    // a halted port keeps the clock low, so the high half waits it out
    while (scl_w !== 1'b1) begin
      #8;
    end
    #24;
  endtask : pulse

  // optional start, then n clocks, msb first; ends with the clock held low
  task automatic frame(input logic start, input logic [7:0] data, input int n);
    if (start) begin
      sda_drv <= 1'b0; // start: data falls while clock high
      #32;
    end
    for (int i = 0; i < n; i++) begin
      pulse(i < 8 ? data[3'(7 - i)] : 1'b1);
    end
    scl_drv <= 1'b0;
    #16 sda_drv <= 1'b1;
  endtask : frame
endmodule : swac_link_model

/* File: serial_wait_ack_irq_control_test.sv */
// self-checking bench for the wait, acknowledge and interrupt-condition block
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module serial_wait_ack_irq_control_test;
  import swac_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic sys_clk;
  logic sys_rst;
  swac_addr_t avs_address;
  logic avs_read;
  logic avs_write;
  swac_word_t avs_writedata;
  swac_be_t avs_byteenable;
  swac_word_t avs_readdata;
  logic avs_waitrequest;
  logic scl_o;
  logic scl_oe;
  logic sda_o;
  logic sda_oe;
  logic scl_drv;
  logic sda_drv;
  wire scl_w;
  wire sda_w;
  int n_fail;
  int compares;
  int cycles;
  swac_word_t rd;

  // open-drain wires: pulled up, low if any party pulls
  assign scl_w = (scl_oe ? scl_o : 1'b1) & scl_drv;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & sda_drv;

  swac_top dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
  );
  swac_link_model link (.scl_w(scl_w), .scl_drv(scl_drv), .sda_drv(sda_drv));

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // whole run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // avalon access: hold request until waitrequest is sampled low
  // ---------------------------------------------------------------
  task automatic acc(input logic wr, input logic [7:0] a, input swac_word_t d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    // only the cycle ceiling ends a wait that never answers
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task automatic rdchk(input logic [7:0] a, input swac_word_t exp);
    acc(1'b0, a, 32'h0000_0000);
    `CHK(rd, exp)
  endtask : rdchk

  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    n_fail = 0;
    compares = 0;
    cycles = 0;
    sys_rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // reset state: all wait bits clear, port parked in wait
    rdchk(8'h38, 32'h0000_0000);
    rdchk(8'h30, 32'h0000_0000);
    rdchk(8'h3c, 32'h0000_0001);
    rdchk(8'hfc, 32'h0000_0000); // unmapped place
    // i2c receive, irq at counter 8 chosen while still waiting
    acc(1'b1, 8'h40, 32'h0000_0001);
    acc(1'b1, 8'h30, {30'h0, IRQ_AT8});
    acc(1'b1, 8'h38, {28'h0, 2'b01, WAIT_DATA});
    rdchk(8'h38, 32'h0000_0005);
    rdchk(8'h3c, 32'h0000_0000);
    // data wait: halt at the fall with counter 8, ack level driven low
    link.frame(1'b1, 8'ha5, 8);
    repeat (20) @(posedge sys_clk);
    `CHK(scl_oe, 1'b1)
    `CHK(sda_w, 1'b0)
    rdchk(8'h38, 32'h0000_0001);
    rdchk(8'h3c, 32'h0000_0001);
    rdchk(8'h44, 32'h0000_0001);
    rdchk(8'h48, 32'h0000_01a5);
    acc(1'b1, 8'h44, 32'h0000_0001);
    rdchk(8'h44, 32'h0000_0000);
    // forced wait: release, then write zero; one clock later it halts
    acc(1'b1, 8'h38, 32'h0000_0005);
    acc(1'b1, 8'h38, 32'h0000_0001);
    link.frame(1'b0, 8'hff, 1);
    repeat (20) @(posedge sys_clk);
    `CHK(scl_oe, 1'b1)
    rdchk(8'h38, 32'h0000_0001);
    // acknowledge wait: counter wraps, halt at the fall with counter 9
    acc(1'b1, 8'h38, {28'h0, 2'b01, WAIT_ACK});
    link.frame(1'b0, 8'h3c, 10);
    repeat (20) @(posedge sys_clk);
    `CHK(scl_oe, 1'b1)
    rdchk(8'h38, 32'h0000_0002);
    // mid-run reset clears the wait register and the fifo again
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdchk(8'h38, 32'h0000_0000);
    // serial data wait: halt at the rise with counter 8, irq at counter 7
    acc(1'b1, 8'h40, 32'h0000_0000);
    acc(1'b1, 8'h38, {28'h0, 2'b01, WAIT_DATA});
    link.frame(1'b0, 8'h96, 8);
    repeat (20) @(posedge sys_clk);
    `CHK(scl_oe, 1'b1)
    rdchk(8'h38, 32'h0000_0001);
    rdchk(8'h44, 32'h0000_0001);
    rdchk(8'h48, 32'h0000_0196);
    // serial mode keeps the acknowledge bit at zero
    acc(1'b1, 8'h38, 32'h0000_0008);
    rdchk(8'h38, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : serial_wait_ack_irq_control_test
